/* File: rtl/clk_stop_pkg.sv */
/*
 * Shared constants for the output clock stop control block.
 * Assumes one system clock; output clocks are modelled as toggles
 * generated from it, one output half period per half-period count.
 */
package clk_stop_pkg;
    // Synchroniser depth for the stop requests
    localparam int SYNC_STAGES = 2;
    // Cycles to wait after sampling before the stop takes effect (2..6)
    localparam int STOP_WAIT = 2;
    // Longest stop latency in output periods
    localparam int STOP_MAX = 6;
    // Longest restart latency in output periods
    localparam int RESTART_MAX = 2;
    // Output half period in system clocks
    localparam int HALF_PERIOD = 1;
    // Reset value of the stop-enable masks (all stoppable)
    localparam logic RESET_STOPPABLE = 1'b1;
endpackage

/* File: rtl/stop_sync.sv */
/*
 * Multi-stage synchroniser for an asynchronous stop request.
 * Assumes the input may change at any time; output idles high.
 */
module stop_sync #(
    parameter int STAGES = 2
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Raw and synchronised request
    input wire logic async_n_i,
    output logic sync_n_o
);
    // Shift chain; only the next stage, or the output for the last flop, reads each flop
    logic [STAGES-1:0] chain;

    // Shift the request through the chain
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            chain <= '1;
        end else begin
            chain <= {chain[STAGES-2:0], async_n_i}; // R12
        end
    end

    assign sync_n_o = chain[STAGES-1];
endmodule

/* File: rtl/output_clock_stop_control.sv */
/*
 * Stop and restart control for the stoppable output clocks.
 * Assumes the chipset drives active-low stop requests and the
 * management bus supplies per-output stoppable bits as static inputs.
 */
// Notes on behaviour
// R1 - CPU stop request halts CPU outputs only
// R2 - Only outputs marked stoppable obey CPU stop
// R3 - Halt two to six periods after sampling
// R4 - Stopped pair parks true high, complement low
// R5 - Restart synchronously with no runt pulses
// R6 - Restart within two CPU clock cycles
// R7 - PCI stop request halts PCI outputs
// R8 - Free-running PCI and serial ref obey bits
// R9 - Serial ref stops like CPU outputs
// R10 - PCI outputs resume within two periods
// R11 - Serial ref restarts like CPU outputs
// R12 - Synchronise stop inputs before gating clocks
module output_clock_stop_control #(
    parameter int N_CPU = 2,
    parameter int N_SRC = 3,
    parameter int N_FREE_RUNNING_PCI_CLOCK = 2
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Stop requests from the chipset
    input wire logic cpu_clock_stop_n_i,
    input wire logic pci_serial_ref_stop_n_i,
    // Stoppable configuration bits
    input wire logic [N_CPU-1:0] cpu_stoppable_i,
    input wire logic [N_SRC-1:0] src_stoppable_i,
    input wire logic [N_FREE_RUNNING_PCI_CLOCK-1:0] free_running_pci_clock_stoppable_i,
    // CPU differential outputs
    output logic [N_CPU-1:0] cpu_true_leg_o,
    output logic [N_CPU-1:0] cpu_complement_leg_o,
    // Serial reference differential outputs
    output logic [N_SRC-1:0] serial_ref_clock_true_o,
    output logic [N_SRC-1:0] serial_ref_clock_comp_o,
    // Single-ended PCI outputs
    output logic pci_clock_o,
    output logic [N_FREE_RUNNING_PCI_CLOCK-1:0] free_running_pci_clock_o,
    // Stop state seen by the outputs
    output logic cpu_stopped_o,
    output logic pci_stopped_o
);
    // Gate states: running, waiting to stop, parked
    typedef enum logic [2:0] {
        RUN = 3'b001,
        WAIT = 3'b010,
        PARK = 3'b100
    } gate_state_e;

    // Synchronised requests
    logic cpu_stop_sync_n;
    logic pci_stop_sync_n;
    // Reference phase of the internal differential clock
    logic phase;
    logic [3:0] half_cnt;
    // Gate state machines and wait counters
    gate_state_e cpu_state;
    gate_state_e pci_state;
    logic [3:0] cpu_wait;
    logic [3:0] pci_wait;
    // Phase edge: next cycle the phase flips to high (true leg rises)
    logic rise_next;

    // CPU request synchroniser
    stop_sync #(
        .STAGES(clk_stop_pkg::SYNC_STAGES)
    ) u_cpu_sync (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .async_n_i(cpu_clock_stop_n_i),
        .sync_n_o(cpu_stop_sync_n) // R12
    );

    // PCI and serial reference request synchroniser
    stop_sync #(
        .STAGES(clk_stop_pkg::SYNC_STAGES)
    ) u_pci_sync (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .async_n_i(pci_serial_ref_stop_n_i),
        .sync_n_o(pci_stop_sync_n) // R12
    );

    assign rise_next = (half_cnt == 4'(clk_stop_pkg::HALF_PERIOD - 1))
        && !phase;

    // Free-running reference phase generator
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            phase <= 1'b0;
            half_cnt <= 4'h0;
        end else if (half_cnt == 4'(clk_stop_pkg::HALF_PERIOD - 1)) begin
            phase <= !phase;
            half_cnt <= 4'h0;
        end else begin
            half_cnt <= half_cnt + 4'h1;
        end
    end

    // CPU gate: stop only at a rising edge so the park level is high
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cpu_state <= RUN;
            cpu_wait <= 4'h0;
        end else begin
            unique case (cpu_state)
                RUN: begin
                    if (!cpu_stop_sync_n) begin // R1
                        cpu_state <= WAIT;
                        cpu_wait <= 4'h0;
                    end
                end
                WAIT: begin
                    if (cpu_stop_sync_n) begin
                        cpu_state <= RUN;
                    end else if (rise_next && cpu_wait >=
                        4'(clk_stop_pkg::STOP_WAIT)) begin
                        cpu_state <= PARK; // R3
                    end else if (rise_next) begin
                        cpu_wait <= cpu_wait + 4'h1;
                    end
                end
                PARK: begin
                    // Leave only as the phase goes high, no runt pulse
                    if (cpu_stop_sync_n && rise_next) begin
                        cpu_state <= RUN; // R5 R6
                    end
                end
            endcase
        end
    end

    // PCI and serial reference gate, same timing as the CPU gate
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            pci_state <= RUN;
            pci_wait <= 4'h0;
        end else begin
            unique case (pci_state)
                RUN: begin
                    if (!pci_stop_sync_n) begin // R7
                        pci_state <= WAIT;
                        pci_wait <= 4'h0;
                    end
                end
                WAIT: begin
                    if (pci_stop_sync_n) begin
                        pci_state <= RUN;
                    end else if (rise_next && pci_wait >=
                        4'(clk_stop_pkg::STOP_WAIT)) begin
                        pci_state <= PARK; // R9
                    end else if (rise_next) begin
                        pci_wait <= pci_wait + 4'h1;
                    end
                end
                PARK: begin
                    if (pci_stop_sync_n && rise_next) begin
                        pci_state <= RUN; // R10 R11
                    end
                end
            endcase
        end
    end

    // Next output values, gated per output
    logic cpu_park_next;
    logic pci_park_next;
    logic phase_next;

    assign phase_next = (half_cnt == 4'(clk_stop_pkg::HALF_PERIOD - 1))
        ? !phase : phase;
    // Park takes hold on the cycle the phase goes high
    assign cpu_park_next = (cpu_state == PARK && !(cpu_stop_sync_n
        && rise_next)) || (cpu_state == WAIT && !cpu_stop_sync_n
        && rise_next && cpu_wait >= 4'(clk_stop_pkg::STOP_WAIT));
    assign pci_park_next = (pci_state == PARK && !(pci_stop_sync_n
        && rise_next)) || (pci_state == WAIT && !pci_stop_sync_n
        && rise_next && pci_wait >= 4'(clk_stop_pkg::STOP_WAIT));

    // Registered output drivers, one per output
    genvar g;
    generate
        for (g = 0; g < N_CPU; g++) begin : g_cpu
            always_ff @(posedge clk_sys_i) begin
                if (reset_i) begin
                    cpu_true_leg_o[g] <= 1'b0;
                    cpu_complement_leg_o[g] <= 1'b1;
                end else if (cpu_park_next && cpu_stoppable_i[g]) begin
                    cpu_true_leg_o[g] <= 1'b1; // R2 R4
                    cpu_complement_leg_o[g] <= 1'b0;
                end else begin
                    cpu_true_leg_o[g] <= phase_next;
                    cpu_complement_leg_o[g] <= !phase_next;
                end
            end
        end
        for (g = 0; g < N_SRC; g++) begin : g_src
            always_ff @(posedge clk_sys_i) begin
                if (reset_i) begin
                    serial_ref_clock_true_o[g] <= 1'b0;
                    serial_ref_clock_comp_o[g] <= 1'b1;
                end else if (pci_park_next && src_stoppable_i[g]) begin
                    serial_ref_clock_true_o[g] <= 1'b1; // R8 R9
                    serial_ref_clock_comp_o[g] <= 1'b0;
                end else begin
                    serial_ref_clock_true_o[g] <= phase_next;
                    serial_ref_clock_comp_o[g] <= !phase_next;
                end
            end
        end
        for (g = 0; g < N_FREE_RUNNING_PCI_CLOCK; g++) begin : g_free_running_pci_clock
            always_ff @(posedge clk_sys_i) begin
                if (reset_i) begin
                    free_running_pci_clock_o[g] <= 1'b0;
                end else if (pci_park_next && free_running_pci_clock_stoppable_i[g]) begin
                    // Single-ended clocks park low
                    free_running_pci_clock_o[g] <= 1'b0; // R8
                end else begin
                    free_running_pci_clock_o[g] <= phase_next;
                end
            end
        end
    endgenerate

    // Plain PCI output always stops; status flags
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            pci_clock_o <= 1'b0;
            cpu_stopped_o <= 1'b0;
            pci_stopped_o <= 1'b0;
        end else begin
            pci_clock_o <= pci_park_next ? 1'b0 : phase_next; // R7
            cpu_stopped_o <= cpu_park_next;
            pci_stopped_o <= pci_park_next;
        end
    end
endmodule

/* File: verification/output_clock_stop_control_props.sv */
/* Port assertions for the output clock stop control.
   Assumes binding onto the design top module, one clock domain. */
module output_clock_stop_control_props #(
    parameter int N_CPU = 2,
    parameter int N_SRC = 3,
    parameter int N_FREE_RUNNING_PCI_CLOCK = 2
) (
    // Clock, reset, requests and configuration
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic cpu_clock_stop_n_i,
    input wire logic pci_serial_ref_stop_n_i,
    input wire logic [N_CPU-1:0] cpu_stoppable_i,
    input wire logic [N_SRC-1:0] src_stoppable_i,
    input wire logic [N_FREE_RUNNING_PCI_CLOCK-1:0] free_running_pci_clock_stoppable_i,
    // Watched outputs
    input wire logic [N_CPU-1:0] cpu_true_leg_o,
    input wire logic [N_CPU-1:0] cpu_complement_leg_o,
    input wire logic [N_SRC-1:0] serial_ref_clock_true_o,
    input wire logic [N_SRC-1:0] serial_ref_clock_comp_o,
    input wire logic pci_clock_o,
    input wire logic [N_FREE_RUNNING_PCI_CLOCK-1:0] free_running_pci_clock_o,
    input wire logic cpu_stopped_o,
    input wire logic pci_stopped_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    AST_CPU_PAIR: assert property (
        cpu_true_leg_o == ~cpu_complement_leg_o) else $error("cpu pair");
    AST_SRC_PAIR: assert property (
        serial_ref_clock_true_o == ~serial_ref_clock_comp_o)
        else $error("src pair");
    AST_CPU_PARK: assert property (cpu_stopped_o |->
        (cpu_true_leg_o & cpu_stoppable_i) == cpu_stoppable_i)
        else $error("cpu park");
    AST_SRC_PARK: assert property (pci_stopped_o |->
        (serial_ref_clock_true_o & src_stoppable_i) == src_stoppable_i)
        else $error("src park");
    AST_PCI_PARK: assert property (pci_stopped_o |-> !pci_clock_o &&
        !(free_running_pci_clock_o & free_running_pci_clock_stoppable_i))
        else $error("pci park");
    AST_CPU_EARLY: assert property ($fell(cpu_clock_stop_n_i) &&
        !cpu_stopped_o |-> !cpu_stopped_o [*3]) else $error("early stop");
    AST_CPU_STOP: assert property ($fell(cpu_clock_stop_n_i) ##1
        !cpu_clock_stop_n_i [*8] |-> ##[0:8] cpu_stopped_o)
        else $error("late stop");
    AST_CPU_RESTART: assert property ($rose(cpu_clock_stop_n_i)
        |-> ##[1:8] !cpu_stopped_o) else $error("cpu restart");
    AST_PCI_RESTART: assert property ($rose(pci_serial_ref_stop_n_i)
        |-> ##[1:8] !pci_stopped_o) else $error("pci restart");
    AST_CPU_RUN: assert property (!$past(reset_i) &&
        $stable(cpu_stoppable_i) |-> &((cpu_true_leg_o ^
        $past(cpu_true_leg_o)) | cpu_stoppable_i)) else $error("cpu run");
    cover property (cpu_stopped_o);
    cover property (pci_stopped_o);
    cover property ($rose(cpu_clock_stop_n_i) && cpu_stopped_o);
endmodule

bind output_clock_stop_control output_clock_stop_control_props #(
    .N_CPU(N_CPU), .N_SRC(N_SRC), .N_FREE_RUNNING_PCI_CLOCK(N_FREE_RUNNING_PCI_CLOCK)) i_props (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .cpu_clock_stop_n_i(cpu_clock_stop_n_i),
    .pci_serial_ref_stop_n_i(pci_serial_ref_stop_n_i),
    .cpu_stoppable_i(cpu_stoppable_i), .src_stoppable_i(src_stoppable_i),
    .free_running_pci_clock_stoppable_i(free_running_pci_clock_stoppable_i), .cpu_true_leg_o(cpu_true_leg_o),
    .cpu_complement_leg_o(cpu_complement_leg_o),
    .serial_ref_clock_true_o(serial_ref_clock_true_o),
    .serial_ref_clock_comp_o(serial_ref_clock_comp_o),
    .pci_clock_o(pci_clock_o),
    .free_running_pci_clock_o(free_running_pci_clock_o),
    .cpu_stopped_o(cpu_stopped_o), .pci_stopped_o(pci_stopped_o));

/* File: verification/chipset_model.sv */
/* Chipset side: drives the two active-low stop requests.
   Assumes the bench sets the request bits just after an edge. */
module chipset_model (
    input wire logic clk_sys_i,
    input wire logic cpu_req_i,
    input wire logic pci_req_i,
    output logic cpu_clock_stop_n_o,
    output logic pci_serial_ref_stop_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Requests change shortly after the edge, idle high
    always @(posedge clk_sys_i) begin
        cpu_clock_stop_n_o <= #1 ~cpu_req_i;
        pci_serial_ref_stop_n_o <= #1 ~pci_req_i;
    end
endmodule

/* File: verification/output_clock_stop_control_test.sv */
/* Directed bench for the output clock stop control.
   Assumes the chipset model drives the stop pins. */
module output_clock_stop_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys_i, reset_i, cpu_req, pci_req, csn, psn, pck, cst, pst;
    logic [1:0] cpu_st, free_running_pci_clock_st, ct, cc, pf;
    logic [2:0] src_st, st, sc;
    int fails, checks_done;
    output_clock_stop_control i_output_clock_stop_control (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .cpu_clock_stop_n_i(csn), .pci_serial_ref_stop_n_i(psn),
        .cpu_stoppable_i(cpu_st), .src_stoppable_i(src_st),
        .free_running_pci_clock_stoppable_i(free_running_pci_clock_st), .cpu_true_leg_o(ct),
        .cpu_complement_leg_o(cc), .serial_ref_clock_true_o(st),
        .serial_ref_clock_comp_o(sc), .pci_clock_o(pck),
        .free_running_pci_clock_o(pf), .cpu_stopped_o(cst),
        .pci_stopped_o(pst));
    chipset_model i_chipset_model (.clk_sys_i(clk_sys_i),
        .cpu_req_i(cpu_req), .pci_req_i(pci_req),
        .cpu_clock_stop_n_o(csn), .pci_serial_ref_stop_n_o(psn));
    // Compare and count
    task check(input string what, input logic [7:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, got);
        end
    endtask
    // Step one edge, then settle
    task step;
        @(posedge clk_sys_i);
        #1;
    endtask
    // Bounded wait for a stop flag
    task wait_flag(input bit pci, input logic v, output int n);
        n = 0;
        while ((pci ? pst : cst) !== v && n < 40) begin
            step();
            n++;
        end
    endtask
    task t_cpu_stop;
        int n;
        logic [1:0] a;
        logic p;
        cpu_req = 1;
        wait_flag(0, 1, n);
        check("cpu stop lat", 1, n >= 4 && n <= 16);
        check("cpu true", 3, ct);
        check("cpu comp", 0, cc);
        p = pck;
        a = ct;
        step();
        check("pci runs", 1, pck ^ p);
        check("cpu held", a, ct);
        cpu_req = 0;
        wait_flag(0, 0, n);
        check("cpu restart lat", 1, n <= 8);
        a = ct;
        step();
        check("cpu toggles", 3, ct ^ a);
        $display("cpu stop test done");
    endtask
    task t_cpu_mask;
        int n;
        logic [1:0] a;
        cpu_st = 2'h1;
        cpu_req = 1;
        wait_flag(0, 1, n);
        a = ct;
        step();
        check("masked runs", 2, ct ^ a);
        check("unmasked parked", 1, ct[0]);
        check("mixed comp", 2, cc);
        cpu_req = 0;
        wait_flag(0, 0, n);
        cpu_st = 2'h3;
        $display("cpu mask test done");
    endtask
    task t_pci_stop;
        int n;
        logic [2:0] s;
        logic [1:0] a, f;
        logic p;
        src_st = 3'h5;
        free_running_pci_clock_st = 2'h2;
        pci_req = 1;
        wait_flag(1, 1, n);
        check("pci stop lat", 1, n >= 4 && n <= 16);
        check("pci low", 0, pck);
        check("src parked", 5, st & 3'h5);
        s = st;
        f = pf;
        a = ct;
        step();
        check("free_running_pci_clock", 1, {pf[1], pf ^ f});
        check("src run", 2, st ^ s);
        check("src comp", 2, sc);
        check("cpu run", 3, ct ^ a);
        pci_req = 0;
        wait_flag(1, 0, n);
        check("pci restart lat", 1, n <= 8);
        s = st;
        p = pck;
        step();
        check("src resumes", 7, st ^ s);
        check("pci resumes", 1, pck ^ p);
        src_st = 3'h7;
        free_running_pci_clock_st = 2'h3;
        $display("pci stop test done");
    endtask
    task t_cancel;
        int n;
        n = 0;
        cpu_req = 1;
        repeat (3) step();
        cpu_req = 0;
        repeat (20) begin
            step();
            if (cst !== 1'b0) n++;
        end
        check("cancelled", 0, n);
        $display("cancel test done");
    endtask
    // Report and end the run
    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        clk_sys_i = 0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // Watchdog well beyond the expected run
    initial begin
        #20000;
        fails++;
        wrap_up();
    end
    initial begin
        {reset_i, cpu_req, pci_req, cpu_st, src_st, free_running_pci_clock_st} = 10'h3ff;
        {cpu_req, pci_req} = 2'h0;
        fails = 0;
        checks_done = 0;
        repeat (16) @(posedge clk_sys_i);
        #1;
        reset_i = 0;
        repeat (4) step();
        t_cpu_stop();
        t_cpu_mask();
        t_pci_stop();
        t_cancel();
        wrap_up();
    end
endmodule
